/* File: inc/modem_line_consts.svh */
// Constants of the modem-control block: register map, field places,
// status codes and reset values. Definitions only.
`ifndef MODEM_LINE_CONSTS_SVH
`define MODEM_LINE_CONSTS_SVH

// Register byte addresses
`define REG_CTRL          8'h00
`define REG_CONFIG        8'h04
`define REG_STATUS        8'h08
`define REG_LINES         8'h0c

// Control register fields
`define CTRL_QUERY_BIT    0
`define CTRL_UPDATE_BIT   1
`define CTRL_MASK_LO      8
`define CTRL_MASK_HI      15
`define CTRL_RTS_VAL_BIT  16
`define CTRL_DTR_VAL_BIT  17
`define CTRL_DSR_VAL_BIT  18

// Line select mask bits
`define SEL_RTS_BIT       0
`define SEL_DTR_BIT       1
`define SEL_DSR_BIT       2

// Configuration register fields
`define CFG_RS485_BIT     0
`define CFG_DCE_BIT       1
`define CFG_PROTO_LO      4
`define CFG_BAUD_LO       8
`define CFG_PARITY_LO     12
`define CFG_DBITS_LO      16
`define CFG_SBITS_LO      20
`define CFG_FLOW_LO       24
`define CFG_FIELD_W       3

// Accepted field ranges (value must lie below the limit)
`define PROTO_LIMIT       3'h1
`define BAUD_LIMIT        3'h7
`define PARITY_LIMIT      3'h5
`define DBITS_LIMIT       3'h2
`define SBITS_LIMIT       3'h2
`define FLOW_LIMIT        3'h3
`define FLOW_HW           3'h1

// Status word bits
`define STAT_BUSY_BIT     16
`define STAT_ERR_BIT      17

// Status codes
`define ST_OK             16'h0000
`define ST_BAD_PROTO      16'h80a0
`define ST_BAD_BAUD       16'h80a1
`define ST_BAD_PARITY     16'h80a2
`define ST_BAD_DBITS      16'h80a3
`define ST_BAD_SBITS      16'h80a4
`define ST_BAD_FLOW       16'h80a5
`define ST_NO_LINES       16'h80f0
`define ST_HW_FLOW        16'h80f1
`define ST_DSR_ON_DTE     16'h80f2
`define ST_DTR_ON_DCE     16'h80f3
`define ST_ERR_CLASS      4'h8

// Reset values
`define CTRL_RESET        32'h0000_0000
`define CONFIG_RESET      32'h0000_0000

`endif

/* File: inc/modem_line_pkg.sv */
// Types shared by the modem-control block.
// Assumes nothing of its surroundings.
package modem_line_pkg;
	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC
	} seq_state_t;

	// Operation in flight
	typedef enum logic {
		OP_QUERY,
		OP_UPDATE
	} line_op_t;
endpackage

/* File: verilog/serial_modem_line_control.sv */
// Modem handshake line control with an AHB-Lite register slave.
// Assumes one 250 MHz clock, a single AHB-Lite master with this slave's
// hreadyout as hready, and partner lines arriving asynchronously.
`include "modem_line_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module serial_modem_line_control
	import modem_line_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Partner driven lines
	input  wire logic        dsr_in,
	input  wire logic        cts_in,
	// Lines driven by this module
	output logic             rts_out,
	output logic             dtr_out,
	output logic             dsr_out,
	// Completion
	output logic             done,
	output logic             error,
	output logic             new_data_ready,
	output logic      [15:0] status_word,
	// Line state snapshot
	output logic             line_dtr,
	output logic             line_dsr,
	output logic             line_rts,
	output logic             line_cts,
	output logic             line_dcd,
	output logic             line_ring
);

	// Bus phase tracking
	logic        wr_pend_r;
	logic [7:0]  wr_addr_r;
	logic [31:0] hrdata_r;
	logic        addr_ok;
	// Software registers
	logic [31:0] ctrl_r;
	logic [31:0] config_r;
	// Synchronisers and edge detection
	logic [1:0]  dsr_sync_r;
	logic [1:0]  cts_sync_r;
	logic        query_prev_r;
	logic        update_prev_r;
	logic        query_edge;
	logic        update_edge;
	// Sequencer
	seq_state_t  state_r;
	line_op_t    op_r;
	logic [15:0] err_code;
	// Outputs and their registers
	logic        rts_r;
	logic        dtr_r;
	logic        dsr_r;
	logic        done_r;
	logic        error_r;
	logic        ndr_r;
	logic [15:0] status_r;
	logic        snap_dtr_r;
	logic        snap_dsr_r;
	logic        snap_rts_r;
	logic        snap_cts_r;
	// Decoded configuration and control fields
	logic [2:0]  f_proto;
	logic [2:0]  f_baud;
	logic [2:0]  f_parity;
	logic [2:0]  f_dbits;
	logic [2:0]  f_sbits;
	logic [2:0]  f_flow;
	logic [7:0]  sel_mask;
	logic        is_rs485;
	logic        is_dce;

	assign f_proto  = config_r[`CFG_PROTO_LO +: `CFG_FIELD_W];
	assign f_baud   = config_r[`CFG_BAUD_LO +: `CFG_FIELD_W];
	assign f_parity = config_r[`CFG_PARITY_LO +: `CFG_FIELD_W];
	assign f_dbits  = config_r[`CFG_DBITS_LO +: `CFG_FIELD_W];
	assign f_sbits  = config_r[`CFG_SBITS_LO +: `CFG_FIELD_W];
	assign f_flow   = config_r[`CFG_FLOW_LO +: `CFG_FIELD_W];
	assign sel_mask = ctrl_r[`CTRL_MASK_HI:`CTRL_MASK_LO];
	assign is_rs485 = config_r[`CFG_RS485_BIT];
	assign is_dce   = config_r[`CFG_DCE_BIT];

	// Address phase accepted when the bus is ready
	assign addr_ok = hsel & hready & htrans[1];

	// Write address captured for the data phase; no wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
		end else begin
			wr_pend_r <= addr_ok & hwrite;
			wr_addr_r <= haddr[7:0];
		end
	end

	// Read data is chosen in the address phase so it comes from a flop;
	// a read right after a write to the same word returns the old value.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_r <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			case (haddr[7:0])
				`REG_CTRL:   hrdata_r <= ctrl_r;
				`REG_CONFIG: hrdata_r <= config_r;
				`REG_STATUS: hrdata_r <= {14'h0000, error_r,
					state_r != ST_IDLE, status_r};
				`REG_LINES:  hrdata_r <= {23'h000000, dsr_r, dtr_r, rts_r,
					line_ring, line_dcd, snap_cts_r, snap_rts_r,
					snap_dsr_r, snap_dtr_r};
				default:     hrdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Software registers; unmapped writes are dropped with OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r   <= `CTRL_RESET;
			config_r <= `CONFIG_RESET;
		end else if (wr_pend_r && wr_addr_r == `REG_CTRL) begin
			ctrl_r <= hwdata;
		end else if (wr_pend_r && wr_addr_r == `REG_CONFIG) begin
			config_r <= hwdata;
		end
	end

	// Partner lines are asynchronous: two flops before any use.
	// Request bits are levels written by software; act on their rise
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dsr_sync_r    <= 2'b00;
			cts_sync_r    <= 2'b00;
			query_prev_r  <= 1'b0;
			update_prev_r <= 1'b0;
		end else begin
			dsr_sync_r    <= {dsr_sync_r[0], dsr_in};
			cts_sync_r    <= {cts_sync_r[0], cts_in};
			query_prev_r  <= ctrl_r[`CTRL_QUERY_BIT];
			update_prev_r <= ctrl_r[`CTRL_UPDATE_BIT];
		end
	end

	assign query_edge  = ctrl_r[`CTRL_QUERY_BIT] & ~query_prev_r;
	assign update_edge = ctrl_r[`CTRL_UPDATE_BIT] & ~update_prev_r;

	// Outcome of the operation in flight, most basic fault first
	always_comb begin
		err_code = `ST_OK;
		if (is_rs485) begin
			err_code = `ST_NO_LINES;
		end else if (f_proto >= `PROTO_LIMIT) begin
			err_code = `ST_BAD_PROTO;
		end else if (f_baud >= `BAUD_LIMIT) begin
			err_code = `ST_BAD_BAUD;
		end else if (f_parity >= `PARITY_LIMIT) begin
			err_code = `ST_BAD_PARITY;
		end else if (f_dbits >= `DBITS_LIMIT) begin
			err_code = `ST_BAD_DBITS;
		end else if (f_sbits >= `SBITS_LIMIT) begin
			err_code = `ST_BAD_SBITS;
		end else if (f_flow >= `FLOW_LIMIT) begin
			err_code = `ST_BAD_FLOW;
		end else if (op_r == OP_UPDATE) begin
			if (f_flow == `FLOW_HW) begin
				err_code = `ST_HW_FLOW;
			end else if (sel_mask[`SEL_DSR_BIT] && !is_dce) begin
				err_code = `ST_DSR_ON_DTE;
			end else if (sel_mask[`SEL_DTR_BIT] && is_dce) begin
				err_code = `ST_DTR_ON_DCE;
			end
		end
	end

	// Sequencer: one cycle to accept, one to execute; edges while
	// executing are dropped. Query wins when both rise together.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ST_IDLE;
			op_r    <= OP_QUERY;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (query_edge) begin
						state_r <= ST_EXEC;
						op_r    <= OP_QUERY;
					end else if (update_edge) begin
						state_r <= ST_EXEC;
						op_r    <= OP_UPDATE;
					end
				end
				ST_EXEC: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Completion pulses last exactly one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			done_r  <= 1'b0;
			error_r <= 1'b0;
			ndr_r   <= 1'b0;
		end else begin
			ndr_r   <= state_r == ST_EXEC && op_r == OP_QUERY &&
				err_code == `ST_OK;
			done_r  <= state_r == ST_EXEC && op_r == OP_UPDATE &&
				err_code == `ST_OK;
			error_r <= state_r == ST_EXEC &&
				err_code != `ST_OK;
		end
	end

	// Status changes only at completion, so it holds during execution
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_r <= `ST_OK;
		end else if (state_r == ST_EXEC) begin
			status_r <= err_code;
		end
	end

	// Line drivers change only on a clean update, per mask bit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rts_r <= 1'b0;
			dtr_r <= 1'b0;
			dsr_r <= 1'b0;
		end else if (state_r == ST_EXEC && op_r == OP_UPDATE &&
			err_code == `ST_OK) begin
			if (sel_mask[`SEL_RTS_BIT])
				rts_r <= ctrl_r[`CTRL_RTS_VAL_BIT];
			if (sel_mask[`SEL_DTR_BIT])
				dtr_r <= ctrl_r[`CTRL_DTR_VAL_BIT];
			if (sel_mask[`SEL_DSR_BIT])
				dsr_r <= ctrl_r[`CTRL_DSR_VAL_BIT];
		end
	end

	// Snapshot of the lines on a clean query; carrier and ring unsupported
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			snap_dtr_r <= 1'b0;
			snap_dsr_r <= 1'b0;
			snap_rts_r <= 1'b0;
			snap_cts_r <= 1'b0;
			line_dcd   <= 1'b0;
			line_ring  <= 1'b0;
		end else if (state_r == ST_EXEC && op_r == OP_QUERY &&
			err_code == `ST_OK) begin
			line_dcd   <= 1'b0;
			line_ring  <= 1'b0;
			snap_dtr_r <= dtr_r;
			snap_rts_r <= rts_r;
			snap_dsr_r <= dsr_sync_r[1];
			snap_cts_r <= cts_sync_r[1];
		end
	end

	// Port wiring from flops; hreadyout and hresp are tied to constants
	assign hrdata         = hrdata_r;
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;
	assign rts_out        = rts_r;
	assign dtr_out        = dtr_r;
	assign dsr_out        = dsr_r;
	assign done           = done_r;
	assign error          = error_r;
	assign new_data_ready = ndr_r;
	assign status_word    = status_r;
	assign line_dtr       = snap_dtr_r;
	assign line_dsr       = snap_dsr_r;
	assign line_rts       = snap_rts_r;
	assign line_cts       = snap_cts_r;

	// Checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_NDR_ONE_CYCLE: assert property (
		new_data_ready |=> !new_data_ready)
		else $error("new data ready held too long");
	AST_NO_DCD_RING: assert property (
		!line_dcd && !line_ring)
		else $error("carrier or ring not false");
	AST_RS485_QUERY: assert property (
		state_r == ST_EXEC && op_r == OP_QUERY && is_rs485
		|=> error && status_word == `ST_NO_LINES && !new_data_ready)
		else $error("rs485 query not rejected");
	AST_RS485_HOLD: assert property (
		state_r == ST_EXEC && op_r == OP_UPDATE && is_rs485
		|=> $stable(rts_out) && $stable(dtr_out) && $stable(dsr_out)
		&& status_word == `ST_NO_LINES)
		else $error("rs485 update changed lines");
	AST_UPDATE_START: assert property (
		state_r == ST_IDLE && update_edge && !query_edge
		|=> state_r == ST_EXEC && op_r == OP_UPDATE ##1 state_r == ST_IDLE)
		else $error("update did not start on edge");
	AST_HW_FLOW: assert property (
		state_r == ST_EXEC && op_r == OP_UPDATE && !is_rs485 &&
		err_code == `ST_HW_FLOW |=> error && status_word == `ST_HW_FLOW)
		else $error("hardware flow update not rejected");
	// Judged on the ports, whatever fault outranks it in priority
	AST_DSR_DTE: assert property (
		state_r == ST_EXEC && op_r == OP_UPDATE && sel_mask[`SEL_DSR_BIT]
		&& !is_dce |=> !done && $stable(dsr_out))
		else $error("dsr update allowed on dte");
	AST_DTR_DCE: assert property (
		state_r == ST_EXEC && op_r == OP_UPDATE && sel_mask[`SEL_DTR_BIT]
		&& is_dce |=> !done && $stable(dtr_out))
		else $error("dtr update allowed on dce");
	AST_RTS_DRIVE: assert property (
		state_r == ST_EXEC && op_r == OP_UPDATE && err_code == `ST_OK
		&& sel_mask[`SEL_RTS_BIT]
		|=> rts_out == $past(ctrl_r[`CTRL_RTS_VAL_BIT]) && done)
		else $error("rts not driven to requested level");
	AST_ERR_CLASS: assert property (
		error |-> status_word[15:12] == `ST_ERR_CLASS && !done
		&& !new_data_ready)
		else $error("error without error code");
	AST_STATUS_HOLD: assert property (
		state_r == ST_EXEC |-> $stable(status_word))
		else $error("status moved during execution");
	COV_QUERY_OK: cover property (
		state_r == ST_EXEC && op_r == OP_QUERY ##1 new_data_ready);
	COV_UPDATE_OK: cover property (
		state_r == ST_EXEC && op_r == OP_UPDATE ##1 done);
	COV_UPDATE_ERR: cover property (
		state_r == ST_EXEC && op_r == OP_UPDATE ##1 error);

endmodule
`default_nettype wire

/* File: verif/modem_partner.sv */
// Behavioural far-end device for the modem handshake lines.
// Assumes the bench sets the wanted levels on dsr_set and cts_set.
`timescale 1ns/100ps
`default_nettype none

module modem_partner (
	// Timing reference only
	input  wire logic hclk,
	// Levels asked for by the bench
	input  wire logic dsr_set,
	input  wire logic cts_set,
	// Lines seen by the block
	output logic      dsr_in,
	output logic      cts_in
);
	// Move on the falling edge, away from the block's sampling edge,
	// so its synchroniser sees each change half a cycle before it samples
	always @(negedge hclk) begin
		dsr_in <= dsr_set;
		cts_in <= cts_set;
	end
endmodule
`default_nettype wire

/* File: verif/serial_modem_line_control_tb_top.sv */
// Self-checking bench for the modem line control block.
// Assumes the block, its package, header and the partner model.
`include "modem_line_consts.svh"
`timescale 1ns/100ps
`default_nettype none

module serial_modem_line_control_tb_top;
	localparam logic [2:0] F_DONE = 3'h4;
	localparam logic [2:0] F_ERR  = 3'h2;
	localparam logic [2:0] F_NDR  = 3'h1;

	logic        hclk, hresetn, hsel, hwrite, dsr_set, cts_set;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, dsr_in, cts_in;
	logic        rts_out, dtr_out, dsr_out, done, error, new_data_ready;
	logic [15:0] status_word;
	logic        line_dtr, line_dsr, line_rts, line_cts, line_dcd, line_ring;
	wire logic   hready;
	int          err_count, samples_checked;

	// Single slave, so its ready is the bus ready
	assign hready = hreadyout;

	serial_modem_line_control dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .dsr_in(dsr_in),
		.cts_in(cts_in), .rts_out(rts_out), .dtr_out(dtr_out),
		.dsr_out(dsr_out), .done(done), .error(error),
		.new_data_ready(new_data_ready), .status_word(status_word),
		.line_dtr(line_dtr), .line_dsr(line_dsr), .line_rts(line_rts),
		.line_cts(line_cts), .line_dcd(line_dcd), .line_ring(line_ring)
	);

	modem_partner partner (
		.hclk(hclk), .dsr_set(dsr_set), .cts_set(cts_set),
		.dsr_in(dsr_in), .cts_in(cts_in)
	);

	// Free-running 250 MHz clock
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	task automatic close_out();
		$display("Checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Bounded wait for hready at a rising edge; no latency is assumed
	task automatic wait_ready();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			close_out();
		end
	endtask

	// One single word transfer, address phase then data phase
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] r);
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		r = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask

	function automatic logic [31:0] ctl(input logic u, input logic [7:0] m,
		input logic r, input logic d, input logic s);
		return {13'h0000, s, d, r, m, 6'h00, u, ~u};
	endfunction

	// Clear then set the request bit, then judge the completion pulse
	task automatic do_op(input logic [31:0] cfg, input logic [31:0] c,
		input logic [2:0] fl, input logic [15:0] code);
		logic [2:0] keep;
		int n;
		keep = {rts_out, dtr_out, dsr_out};
		wr(`REG_CONFIG, cfg);
		wr(`REG_CTRL, c & 32'hffff_fffc);
		wr(`REG_CTRL, c);
		n = 0;
		do begin
			@(posedge hclk);
			#1;
			n++;
		end while ({done, error, new_data_ready} === 3'h0 && n < 10);
		chk("pulse", fl, {done, error, new_data_ready});
		chk("status", code, status_word);
		if (fl == F_ERR)
			chk("lines kept", keep, {rts_out, dtr_out, dsr_out});
		if (n >= 10)
			close_out();
		@(posedge hclk);
		#1;
		chk("pulse end", 0, {done, error, new_data_ready});
		chk("status held", code, status_word);
	endtask

	task automatic sc_reset();
		#1;
		chk("reset status", 0, status_word);
		chk("reset flags", 0, {done, error, new_data_ready});
		chk("dcd ring", 0, {line_dcd, line_ring});
		chk("ready resp", 32'h2, {hreadyout, hresp});
	endtask

	// Masks alone and combined; unselected lines keep their level
	task automatic sc_update();
		do_op(0, ctl(1, 8'h03, 1, 1, 0), F_DONE, `ST_OK);
		chk("drive", 3'h6, {rts_out, dtr_out, dsr_out});
		do_op(0, ctl(1, 8'h01, 0, 0, 1), F_DONE, `ST_OK);
		chk("rts only", 3'h2, {rts_out, dtr_out, dsr_out});
		do_op(2, ctl(1, 8'h04, 0, 0, 1), F_DONE, `ST_OK);
		chk("dsr on dce", 3'h3, {rts_out, dtr_out, dsr_out});
	endtask

	task automatic sc_query();
		dsr_set <= 1'b1;
		cts_set <= 1'b0;
		do_op(0, 32'h1, F_NDR, `ST_OK);
		chk("snap a", 6'h30, {line_dtr, line_dsr, line_rts, line_cts,
			line_dcd, line_ring});
		dsr_set <= 1'b0;
		cts_set <= 1'b1;
		do_op(0, 32'h1, F_NDR, `ST_OK);
		chk("snap b", 6'h24, {line_dtr, line_dsr, line_rts, line_cts,
			line_dcd, line_ring});
	endtask

	// Each refused update tries to move a line that must stay put; the other refusals are queries
	task automatic sc_errors();
		do_op(1, 32'h1, F_ERR, `ST_NO_LINES);
		do_op(1, ctl(1, 8'h01, 1, 0, 0), F_ERR, `ST_NO_LINES);
		do_op(32'h0100_0000, ctl(1, 8'h01, 1, 0, 0), F_ERR,
			`ST_HW_FLOW);
		do_op(0, ctl(1, 8'h04, 0, 0, 0), F_ERR, `ST_DSR_ON_DTE);
		do_op(2, ctl(1, 8'h02, 0, 0, 0), F_ERR, `ST_DTR_ON_DCE);
		do_op(32'h10, 32'h1, F_ERR, `ST_BAD_PROTO);
		do_op(32'h700, 32'h1, F_ERR, `ST_BAD_BAUD);
		do_op(32'h5000, 32'h1, F_ERR, `ST_BAD_PARITY);
		do_op(32'h2_0000, 32'h1, F_ERR, `ST_BAD_DBITS);
		do_op(32'h20_0000, 32'h1, F_ERR, `ST_BAD_SBITS);
		do_op(32'h300_0000, 32'h1, F_ERR, `ST_BAD_FLOW);
	endtask

	// Unmapped read, read-only status, line readback
	task automatic sc_regs();
		ahb(1'b0, 8'h40, 0, rd);
		chk("unmapped", 0, rd);
		wr(`REG_STATUS, 32'h0000_1234);
		ahb(1'b0, `REG_STATUS, 0, rd);
		chk("status ro", {16'h0000, `ST_BAD_FLOW}, rd);
		ahb(1'b0, `REG_LINES, 0, rd);
		// Drives rts 0, dtr 1, dsr 1; last clean query saw dtr and cts
		chk("line readback", 32'h0000_0189, rd);
	endtask

	// Drive everything at time zero, hold reset for ten clocks
	initial begin
		err_count = 0;
		samples_checked = 0;
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		dsr_set = 1'b0;
		cts_set = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		sc_reset();
		sc_update();
		sc_query();
		sc_errors();
		sc_regs();
		close_out();
	end
endmodule
`default_nettype wire
